// [common/pcc_pkg.sv]
// Contract
// - clock-out write protect: resets zero, locks later writes
// - lock-loss reset enable gates system reset
// - factor-write lock loss never resets
// - second clock-out mode: strengths, 11 drives high
// - second mode resets ones, cleared when pins 01
// - mode changes switch output without glitches
// - first clock-out mode uses same encoding
// - first mode resets zero, ones when pins 01
// - synth control supervisor only, write if unprotected
// - synth write protect resets zero, locks writes
// - synth enable set-only, loaded from pins
// - enable low: crystal clocks; high: oscillator
// - prescale enable selects crystal or crystal/128
// - stop select: crystal half/256th or oscillator
// - multiplier equals factor plus one
// - factor write drops lock, clocks gated
// - factor resets to 0 or 400
// - divider control supervisor only, write if unprotected
// - divider write protect resets zero, locks writes
// - divider control resets to all zeros
// - sync divider 1/4/16/64, no lock loss
// - clock-out control supervisor-only access
package pcc_pkg;
    localparam logic [7:0]  PCC_CLKO_OFFS    = 8'h00;
    localparam logic [7:0]  PCC_PLL_OFFS     = 8'h04;
    localparam logic [7:0]  PCC_CDV_OFFS     = 8'h08;
    localparam logic [7:0]  PCC_STAT_OFFS    = 8'h0C;
    localparam int          PCC_CLKO_WP_BIT  = 7;
    localparam int          PCC_LOCK_LOSS_RESET_ENABLE_BIT    = 5;
    localparam int          PCC_SECOND_CLOCK_OUT_MODE_LSB     = 2;
    localparam int          PCC_FIRST_CLOCK_OUT_MODE_LSB     = 0;
    localparam int          PCC_SYNTH_ENABLE_BIT    = 15;
    localparam int          PCC_SYNTH_WRITE_PROTECT_BIT    = 14;
    localparam int          PCC_INPUT_PRESCALE_ENABLE_BIT    = 13;
    localparam int          PCC_STOP_MODE_CLOCK_SELECT_BIT    = 12;
    localparam int          PCC_DIVIDER_WRITE_PROTECT_BIT    = 15;
    localparam int          PCC_SYNC_CLOCK_DIVIDER_LSB     = 13;
    localparam logic [11:0] PCC_MF_RST_HI    = 12'h190;
    localparam logic [11:0] PCC_MF_RST_LO    = 12'h000;
    localparam logic [15:0] PCC_CDV_RST      = 16'h0000;
    localparam logic [1:0]  PCC_MODE_OFF     = 2'h3;
    localparam logic [1:0]  PCC_PINS_SWAP    = 2'h1;
    localparam logic [1:0]  PCC_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  PCC_RESP_SLVERR  = 2'h2;
    localparam int          PCC_RELOCK_CYC   = 64;

    typedef struct packed {
        logic [1:0] strength;
        logic       clk;
    } pcc_clk_out_t;
endpackage : pcc_pkg

// [core/pcc_clock_ctrl.sv]
`timescale 1ns/1ps
module pcc_clock_ctrl
    import pcc_pkg::*;
#(
    parameter int RELOCK_CYCLES = PCC_RELOCK_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  mode_select_pins,
    input  wire logic        crystal_input,
    input  wire logic        synth_clock,
    input  wire logic        synth_locked,
    input  wire logic        low_power_stop_instr,
    output pcc_clk_out_t     first_clock_out_pin,
    output pcc_clk_out_t     second_clock_out_pin,
    output logic             system_reset_req,
    output logic             synth_run,
    output logic             synth_relock,
    output logic [11:0]      multiplication_factor,
    output logic             input_prescale_enable,
    output logic             clock_from_synth,
    output logic             integration_clock_from_crystal,
    output logic [6:0]       sync_clock_divide
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] pins_s1_reg, pins_s2_reg;
    logic [2:0] xtal_s_reg, synth_s_reg;
    logic [1:0] lock_s_reg, stop_s_reg;
    logic       boot_reg;

    always_ff @(posedge aclk) begin
        pins_s1_reg <= mode_select_pins;
        pins_s2_reg <= pins_s1_reg;
        xtal_s_reg  <= {xtal_s_reg[1:0], crystal_input};
        synth_s_reg <= {synth_s_reg[1:0], synth_clock};
        lock_s_reg  <= {lock_s_reg[0], synth_locked};
        stop_s_reg  <= {stop_s_reg[0], low_power_stop_instr};
    end

    wire [1:0] pins        = pins_s2_reg;
    wire       xtal_lvl    = xtal_s_reg[1];
    wire       xtal_rise   = xtal_s_reg[1] & ~xtal_s_reg[2];
    wire       synth_lvl   = synth_s_reg[1];
    wire       synth_rise  = synth_s_reg[1] & ~synth_s_reg[2];
    wire       locked_lvl  = lock_s_reg[1];
    wire       stopping    = stop_s_reg[1];

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic        aw_sup_reg;
    logic [3:0]  w_strb_reg;

    // a low ready means that channel holds a word not yet used
    wire wr_go     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire wr_clko   = wr_go & aw_sup_reg & aw_addr_reg == PCC_CLKO_OFFS;
    wire wr_pll    = wr_go & aw_sup_reg & aw_addr_reg == PCC_PLL_OFFS;
    wire wr_cdv    = wr_go & aw_sup_reg & aw_addr_reg == PCC_CDV_OFFS;
    wire wr_known  = aw_addr_reg == PCC_CLKO_OFFS
                   | aw_addr_reg == PCC_PLL_OFFS
                   | aw_addr_reg == PCC_CDV_OFFS
                   | aw_addr_reg == PCC_STAT_OFFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_addr_reg   <= 8'h00;
            aw_sup_reg    <= 1'b0;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= PCC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
                aw_sup_reg  <= s_axi_awprot[0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                // user-mode or unmapped access answers with an error
                s_axi_bresp  <= (aw_sup_reg && wr_known) ? PCC_RESP_OKAY
                                                         : PCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // clock-out control
    // ---------------------------------------------------------------
    logic       clko_wp_reg, lock_loss_reset_enable_reg;
    logic [1:0] first_clock_out_mode_reg, second_clock_out_mode_reg;
    wire        pins_swap = pins == PCC_PINS_SWAP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clko_wp_reg <= 1'b0;
            lock_loss_reset_enable_reg   <= 1'b0;
            first_clock_out_mode_reg    <= 2'h0;
            second_clock_out_mode_reg    <= PCC_MODE_OFF;
        end else if (boot_reg) begin
            first_clock_out_mode_reg <= pins_swap ? PCC_MODE_OFF : 2'h0;
            second_clock_out_mode_reg <= pins_swap ? 2'h0 : PCC_MODE_OFF;
        end else if (wr_clko && !clko_wp_reg && w_strb_reg[0]) begin
            // the write that sets protection still lands
            clko_wp_reg <= w_data_reg[PCC_CLKO_WP_BIT];
            lock_loss_reset_enable_reg   <= w_data_reg[PCC_LOCK_LOSS_RESET_ENABLE_BIT];
            second_clock_out_mode_reg    <= w_data_reg[PCC_SECOND_CLOCK_OUT_MODE_LSB +: 2];
            first_clock_out_mode_reg    <= w_data_reg[PCC_FIRST_CLOCK_OUT_MODE_LSB +: 2];
        end
    end

    // ---------------------------------------------------------------
    // synth control
    // ---------------------------------------------------------------
    logic        synth_enable_reg, synth_write_protect_reg, input_prescale_enable_reg, stop_mode_clock_select_reg;
    logic [11:0] mf_reg;
    logic [15:0] relock_cnt_reg;
    logic        sw_unlock_reg;
    wire         pll_we = wr_pll & ~synth_write_protect_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            synth_enable_reg <= 1'b0;
            synth_write_protect_reg <= 1'b0;
            input_prescale_enable_reg <= 1'b0;
            stop_mode_clock_select_reg <= 1'b0;
            mf_reg    <= PCC_MF_RST_LO;
            boot_reg  <= 1'b1;
        end else if (boot_reg) begin
            // pins caught on the first edge after release
            boot_reg  <= 1'b0;
            synth_enable_reg <= pins != 2'b00;
            input_prescale_enable_reg <= pins[1];
            mf_reg    <= pins[0] ? PCC_MF_RST_HI
                                 : PCC_MF_RST_LO;
        end else if (pll_we) begin
            synth_write_protect_reg <= w_data_reg[PCC_SYNTH_WRITE_PROTECT_BIT];
            synth_enable_reg <= synth_enable_reg | w_data_reg[PCC_SYNTH_ENABLE_BIT];
            input_prescale_enable_reg <= w_data_reg[PCC_INPUT_PRESCALE_ENABLE_BIT];
            stop_mode_clock_select_reg <= w_data_reg[PCC_STOP_MODE_CLOCK_SELECT_BIT];
            mf_reg    <= w_data_reg[11:0];
        end
    end

    // a factor write forces a relock window; lock loss inside it
    // is self-inflicted and must not reset the chip
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relock_cnt_reg <= 16'h0000;
            sw_unlock_reg  <= 1'b0;
        end else if (pll_we) begin
            relock_cnt_reg <= 16'(RELOCK_CYCLES);
            sw_unlock_reg  <= 1'b1;
        end else if (relock_cnt_reg != 16'h0000) begin
            relock_cnt_reg <= relock_cnt_reg - 16'h0001;
        end else if (locked_lvl) begin
            sw_unlock_reg  <= 1'b0;
        end
    end

    wire relocking  = relock_cnt_reg != 16'h0000;
    wire stop_xtal  = stopping & ~stop_mode_clock_select_reg;
    wire run_synth  = synth_enable_reg & ~stop_xtal;
    wire lock_lost  = run_synth & ~relocking & ~locked_lvl;
    wire want_reset = lock_loss_reset_enable_reg & lock_lost & ~sw_unlock_reg;
    wire gated      = run_synth & (relocking | ~locked_lvl);
    wire src_clk    = run_synth ? synth_lvl : xtal_lvl;
    wire src_rise   = run_synth ? synth_rise : xtal_rise;

    // ---------------------------------------------------------------
    // divider control and sync clock
    // ---------------------------------------------------------------
    logic       divider_write_protect_reg;
    logic [1:0] sync_clock_divider_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider_write_protect_reg <= PCC_CDV_RST[PCC_DIVIDER_WRITE_PROTECT_BIT];
            sync_clock_divider_reg  <= PCC_CDV_RST[PCC_SYNC_CLOCK_DIVIDER_LSB +: 2];
        end else if (wr_cdv && !divider_write_protect_reg) begin
            divider_write_protect_reg <= w_data_reg[PCC_DIVIDER_WRITE_PROTECT_BIT];
            sync_clock_divider_reg  <= w_data_reg[PCC_SYNC_CLOCK_DIVIDER_LSB +: 2];
        end
    end

    function automatic logic [6:0] pcc_sync_div(input logic [1:0] code);
        pcc_sync_div = 7'(1) << {code, 1'b0};
    endfunction : pcc_sync_div

    // ---------------------------------------------------------------
    // clock outputs: strength and off state change only while the
    // source is low or gated, so no runt pulse reaches a pin
    // ---------------------------------------------------------------
    logic [1:0] first_clock_out_mode_live_reg, second_clock_out_mode_live_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_clock_out_mode_live_reg <= 2'h0;
            second_clock_out_mode_live_reg <= PCC_MODE_OFF;
            first_clock_out_pin  <= '{strength: 2'h0, clk: 1'b0};
            second_clock_out_pin <= '{strength: PCC_MODE_OFF, clk: 1'b1};
        end else begin
            if (!src_clk || gated) begin
                first_clock_out_mode_live_reg <= first_clock_out_mode_reg;
                second_clock_out_mode_live_reg <= second_clock_out_mode_reg;
            end
            first_clock_out_pin.strength  <= first_clock_out_mode_live_reg;
            second_clock_out_pin.strength <= second_clock_out_mode_live_reg;
            first_clock_out_pin.clk  <= first_clock_out_mode_live_reg == PCC_MODE_OFF
                                      | (src_clk & ~gated);
            second_clock_out_pin.clk <= second_clock_out_mode_live_reg == PCC_MODE_OFF
                                      | (src_clk & ~gated);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_reset_req      <= 1'b0;
            synth_run             <= 1'b0;
            synth_relock          <= 1'b0;
            multiplication_factor <= PCC_MF_RST_LO;
            input_prescale_enable <= 1'b0;
            clock_from_synth      <= 1'b0;
            integration_clock_from_crystal <= 1'b1;
            sync_clock_divide     <= 7'h01;
        end else begin
            system_reset_req      <= want_reset;
            synth_run             <= run_synth;
            synth_relock          <= relocking;
            multiplication_factor <= mf_reg;
            input_prescale_enable <= input_prescale_enable_reg;
            clock_from_synth      <= run_synth;
            integration_clock_from_crystal <= ~run_synth;
            sync_clock_divide     <= pcc_sync_div(sync_clock_divider_reg);
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    wire [7:0]  clko_word = {clko_wp_reg, 1'b0, lock_loss_reset_enable_reg, 1'b0,
                             second_clock_out_mode_reg, first_clock_out_mode_reg};
    wire [15:0] pll_word  = {synth_enable_reg, synth_write_protect_reg, input_prescale_enable_reg, stop_mode_clock_select_reg,
                             mf_reg};
    wire [15:0] cdv_word  = {divider_write_protect_reg, sync_clock_divider_reg, 13'h0000};
    wire [3:0]  stat_word = {src_rise, gated, locked_lvl, run_synth};
    wire [7:0]  ar_addr   = {s_axi_araddr[7:2], 2'b00};
    wire        ar_sup    = s_axi_arprot[0];
    wire [31:0] rd_word   =
        ar_addr == PCC_CLKO_OFFS ? {24'h000000, clko_word} :
        ar_addr == PCC_PLL_OFFS  ? {16'h0000, pll_word} :
        ar_addr == PCC_CDV_OFFS  ? {16'h0000, cdv_word} :
        ar_addr == PCC_STAT_OFFS ? {28'h0000000, stat_word} :
                                   32'h00000000;
    wire        rd_known  = ar_addr == PCC_CLKO_OFFS
                          | ar_addr == PCC_PLL_OFFS
                          | ar_addr == PCC_CDV_OFFS
                          | ar_addr == PCC_STAT_OFFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= PCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
            // user-mode reads see zeros and an error
            s_axi_rdata  <= ar_sup ? rd_word : 32'h00000000;
            s_axi_rresp  <= (ar_sup && rd_known) ? PCC_RESP_OKAY
                                                 : PCC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_clko_wp_lock: assert property (
        @(posedge aclk) disable iff (!aresetn)
        clko_wp_reg && !boot_reg |=> $stable(first_clock_out_mode_reg) && $stable(second_clock_out_mode_reg))
        else $error("clock-out control changed while protected");
    a_no_sw_reset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sw_unlock_reg |=> !system_reset_req)
        else $error("reset raised by factor write");
    a_lock_loss_reset_enable_gate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !lock_loss_reset_enable_reg |=> !system_reset_req)
        else $error("reset raised while disabled");
    a_pll_wp_lock: assert property (
        @(posedge aclk) disable iff (!aresetn)
        synth_write_protect_reg |=> $stable(mf_reg) && synth_write_protect_reg)
        else $error("synth control changed while protected");
    a_synth_enable_sticky: assert property (
        @(posedge aclk) disable iff (!aresetn)
        synth_enable_reg && !boot_reg |=> synth_enable_reg)
        else $error("synth enable cleared by software");
    a_cdv_wp_lock: assert property (
        @(posedge aclk) disable iff (!aresetn)
        divider_write_protect_reg |=> $stable(sync_clock_divider_reg) && divider_write_protect_reg)
        else $error("divider changed while protected");
    a_mf_relock: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pll_we |=> relocking ##1 synth_relock)
        else $error("factor write did not drop lock");
    a_off_high: assert property (
        @(posedge aclk) disable iff (!aresetn)
        second_clock_out_mode_live_reg == PCC_MODE_OFF |=> second_clock_out_pin.clk)
        else $error("disabled clock output not high");
    a_boot_com: assert property (
        @(posedge aclk) disable iff (!aresetn)
        boot_reg && pins_swap |=> first_clock_out_mode_reg == PCC_MODE_OFF && second_clock_out_mode_reg == 2'h0)
        else $error("clock-out reset modes wrong");

endmodule : pcc_clock_ctrl

// [tb/pcc_osc_model.sv]
`timescale 1ns/1ps
// ------------------------------------------
// crystal and synthesiser stand-in
// ------------------------------------------
module pcc_osc_model (
    input  wire logic aclk,
    input  wire logic synth_run,
    input  wire logic synth_relock,
    input  wire logic drop_lock,
    output logic      crystal_input,
    output logic      synth_clock,
    output logic      synth_locked
);
    logic [3:0] div_reg;
    logic [3:0] lock_cnt_reg;

    initial begin
        div_reg = 4'h0;
        lock_cnt_reg = 4'h0;
    end
    // sources kept slow so the sampled copies inside stay faithful
    always @(posedge aclk) div_reg <= div_reg + 4'h1;
    assign crystal_input = div_reg[3];
    // no output while stopped or hunting for lock
    assign synth_clock = synth_run && synth_locked && div_reg[1];
    // a new factor or a commanded fault costs a relock delay
    always @(posedge aclk) begin
        if (!synth_run || synth_relock || drop_lock) lock_cnt_reg <= 4'hF;
        else if (lock_cnt_reg != 4'h0) lock_cnt_reg <= lock_cnt_reg - 4'h1;
    end
    assign synth_locked = synth_run && (lock_cnt_reg == 4'h0);
endmodule : pcc_osc_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import pcc_pkg::*;
    localparam int LIMIT = 20000;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [2:0]  awprot = 3'h0, arprot = 3'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, pins = 2'h3;
    logic        stop = 1'h0, drop = 1'h0, rst_req, run, relock, pre;
    logic        xtal, sclk, locked, from_synth, int_xtal, held;
    logic [11:0] mf;
    logic [6:0]  sdiv;
    pcc_clk_out_t co1, co2;
    int          errors = 0, total_checks = 0, cycles = 0;

    always #5 aclk = ~aclk;

    pcc_clock_ctrl #(.RELOCK_CYCLES(4)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mode_select_pins(pins), .crystal_input(xtal), .synth_clock(sclk),
        .synth_locked(locked), .low_power_stop_instr(stop),
        .first_clock_out_pin(co1), .second_clock_out_pin(co2),
        .system_reset_req(rst_req), .synth_run(run), .synth_relock(relock),
        .multiplication_factor(mf), .input_prescale_enable(pre),
        .clock_from_synth(from_synth),
        .integration_clock_from_crystal(int_xtal), .sync_clock_divide(sdiv)
    );

    pcc_osc_model osc_u (
        .aclk(aclk), .synth_run(run), .synth_relock(relock),
        .drop_lock(drop), .crystal_input(xtal), .synth_clock(sclk),
        .synth_locked(locked)
    );

    // ------------------------------------------
    // helpers
    // ------------------------------------------
    task automatic close_out;
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    always @(posedge aclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] p, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        // one edge between calls, so bready is never set twice in a step
        @(posedge aclk);
        awaddr <= a;
        awprot <= p;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'h1) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready === 1'h1) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        @(posedge aclk);
        while (bvalid !== 1'h1) @(posedge aclk);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [2:0] p,
                      input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arprot <= p;
        arvalid <= 1'h1;
        rready <= 1'h1;
        @(posedge aclk);
        while (arready !== 1'h1) @(posedge aclk);
        arvalid <= 1'h0;
        @(posedge aclk);
        while (rvalid !== 1'h1) @(posedge aclk);
        rready <= 1'h0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    task automatic do_reset(input logic [1:0] p);
        pins <= p;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    // disabled pins must stay high the whole time
    task automatic watch_off(input int n);
        held = 1'h1;
        repeat (n) begin
            @(posedge aclk);
            held = held & co1.clk & co2.clk;
        end
    endtask : watch_off

    // a reset request raised at any edge of the window is caught
    task automatic watch_rst(input int n);
        held = 1'h0;
        repeat (n) begin
            @(posedge aclk);
            held = held | rst_req;
        end
    endtask : watch_rst

    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial begin
        do_reset(2'h3);
        rd(PCC_PLL_OFFS, 3'h1, 32'hA190, PCC_RESP_OKAY);
        rd(PCC_CLKO_OFFS, 3'h1, 32'h0C, PCC_RESP_OKAY);
        rd(PCC_CDV_OFFS, 3'h1, 32'h0, PCC_RESP_OKAY);
        chk(pre, 1'h1);
        rd(PCC_CLKO_OFFS, 3'h0, 32'h0, PCC_RESP_SLVERR);
        wr(PCC_PLL_OFFS, 32'h4000, 3'h0, PCC_RESP_SLVERR);
        wr(PCC_CDV_OFFS, 32'h8000, 3'h0, PCC_RESP_SLVERR);
        rd(PCC_PLL_OFFS, 3'h1, 32'hA190, PCC_RESP_OKAY);
        rd(8'h10, 3'h1, 32'h0, PCC_RESP_SLVERR);
        wr(PCC_CLKO_OFFS, 32'h06, 3'h1, PCC_RESP_OKAY);
        repeat (24) @(posedge aclk);
        chk(co2.strength, 2'h1);
        chk(co1.strength, 2'h2);
        drop <= 1'h1;
        repeat (3) @(posedge aclk);
        drop <= 1'h0;
        watch_rst(30);
        chk(held, 1'h0);
        wr(PCC_CLKO_OFFS, 32'h2D, 3'h1, PCC_RESP_OKAY);
        wr(PCC_PLL_OFFS, 32'h0005, 3'h1, PCC_RESP_OKAY);
        @(posedge aclk);
        chk(relock, 1'h1);
        watch_rst(40);
        chk(held, 1'h0);
        rd(PCC_PLL_OFFS, 3'h1, 32'h8005, PCC_RESP_OKAY);
        chk(mf, 12'h005);
        chk(pre, 1'h0);
        chk(from_synth, 1'h1);
        chk(run, 1'h1);
        drop <= 1'h1;
        repeat (3) @(posedge aclk);
        drop <= 1'h0;
        watch_rst(20);
        chk(held, 1'h1);
        wr(PCC_PLL_OFFS, 32'h5007, 3'h1, PCC_RESP_OKAY);
        wr(PCC_PLL_OFFS, 32'h0009, 3'h1, PCC_RESP_OKAY);
        rd(PCC_PLL_OFFS, 3'h1, 32'hD007, PCC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(PCC_CDV_OFFS, 32'(i) << 13, 3'h1, PCC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk(sdiv, 32'h1 << (2 * i));
        end
        wr(PCC_CDV_OFFS, 32'hA000, 3'h1, PCC_RESP_OKAY);
        wr(PCC_CDV_OFFS, 32'h0000, 3'h1, PCC_RESP_OKAY);
        rd(PCC_CDV_OFFS, 3'h1, 32'hA000, PCC_RESP_OKAY);
        wr(PCC_CLKO_OFFS, 32'h8F, 3'h1, PCC_RESP_OKAY);
        wr(PCC_CLKO_OFFS, 32'h00, 3'h1, PCC_RESP_OKAY);
        rd(PCC_CLKO_OFFS, 3'h1, 32'h8F, PCC_RESP_OKAY);
        repeat (24) @(posedge aclk);
        watch_off(32);
        chk(held, 1'h1);
        do_reset(2'h1);
        rd(PCC_PLL_OFFS, 3'h1, 32'h8190, PCC_RESP_OKAY);
        rd(PCC_CLKO_OFFS, 3'h1, 32'h03, PCC_RESP_OKAY);
        rd(PCC_CDV_OFFS, 3'h1, 32'h0, PCC_RESP_OKAY);
        chk(rst_req, 1'h0);
        repeat (24) @(posedge aclk);
        chk(co1.strength, 2'h3);
        chk(co2.strength, 2'h0);
        stop <= 1'h1;
        repeat (8) @(posedge aclk);
        chk(int_xtal, 1'h1);
        wr(PCC_PLL_OFFS, 32'h9190, 3'h1, PCC_RESP_OKAY);
        repeat (8) @(posedge aclk);
        chk(int_xtal, 1'h0);
        stop <= 1'h0;
        do_reset(2'h0);
        rd(PCC_PLL_OFFS, 3'h1, 32'h0000, PCC_RESP_OKAY);
        chk(from_synth, 1'h0);
        chk(run, 1'h0);
        wr(PCC_PLL_OFFS, 32'h8000, 3'h1, PCC_RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk(from_synth, 1'h1);
        close_out();
    end
endmodule : testbench
